// ==== bench/slseq_asserts.sv ====
// Purpose: checks controller lamps, update watchdog, store echo and restart pulse
// Assumes: bound to slseq_top, synchronous active-low reset
// Notes:   update flag bounds allow one cycle of slack for its register
`timescale 1ns/1ps
module slseq_asserts #(
  parameter longint unsigned UPDATE_CYCLES = 50
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic system_fault_in,
  input wire logic fw_load_fail_in,
  input wire logic fw_update_in,
  input wire logic new_cfg_in,
  input wire logic activate_done_in,
  input wire logic blue_status_lamp_out,
  input wire logic orange_fault_lamp_out,
  input wire logic update_failed_out,
  input wire logic store_write_out,
  input wire logic restart_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  longint unsigned upd_cnt;
  // own count of the update run, kept apart from the design's counter
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !fw_update_in) upd_cnt <= 0;
    else upd_cnt <= upd_cnt + 1;
  end
  property p_normal; !fw_load_fail_in && !fw_update_in && !system_fault_in
    |=> blue_status_lamp_out && !orange_fault_lamp_out; endproperty
  a_normal: assert property (p_normal) else $error("normal lamps wrong");
  property p_fault; system_fault_in && !fw_load_fail_in && !fw_update_in
    |=> blue_status_lamp_out; endproperty
  a_fault: assert property (p_fault) else $error("blue dropped in fault");
  property p_load; fw_load_fail_in [*2] |-> orange_fault_lamp_out && !blue_status_lamp_out;
  endproperty
  a_load: assert property (p_load) else $error("load fail lamps wrong");
  property p_upd; fw_update_in && !fw_load_fail_in
    |=> orange_fault_lamp_out && blue_status_lamp_out; endproperty
  a_upd: assert property (p_upd) else $error("update lamps wrong");
  property p_late; upd_cnt > UPDATE_CYCLES + 1 |-> update_failed_out; endproperty
  a_late: assert property (p_late) else $error("update flag missing");
  property p_early; upd_cnt + 1 < UPDATE_CYCLES |-> !update_failed_out; endproperty
  a_early: assert property (p_early) else $error("update flag early");
  property p_store; $rose(new_cfg_in) |=> store_write_out; endproperty
  a_store: assert property (p_store) else $error("store write missing");
  property p_rst; $rose(activate_done_in) |=> restart_out ##1 !restart_out; endproperty
  a_rst: assert property (p_rst) else $error("restart pulse wrong");
  property p_rcause; restart_out |-> $past(activate_done_in) && !$past(activate_done_in, 2);
  endproperty
  a_rcause: assert property (p_rcause) else $error("restart without cause");
  c_fault: cover property (system_fault_in && orange_fault_lamp_out);
  c_fail: cover property (update_failed_out);
  c_rst: cover property (restart_out);
endmodule
bind slseq_top slseq_asserts #(.UPDATE_CYCLES(UPDATE_CYCLES)) u_chk (.clk_in, .reset_n_in,
  .system_fault_in, .fw_load_fail_in, .fw_update_in, .new_cfg_in, .activate_done_in,
  .blue_status_lamp_out, .orange_fault_lamp_out, .update_failed_out, .store_write_out,
  .restart_out);

// ==== bench/slseq_panel.sv ====
// Purpose: operator's view of the lamps, counting flashes per lamp
// Assumes: lamps are high while lit
// Notes:   a window of whole pattern periods yields an exact flash count
`timescale 1ns/1ps
module slseq_panel (
  // clock and window control
  input  wire logic       clk_in,
  input  wire logic       clear_in,
  // lamps and counts
  input  wire logic [4:0] lamps_in,
  output logic [7:0]      rises_out [5]
);
  logic [4:0] last;
  always_ff @(posedge clk_in) begin
    last <= lamps_in;
    for (int i = 0; i < 5; i++) begin
      if (clear_in) rises_out[i] <= 8'h00;
      else if (lamps_in[i] && !last[i]) rises_out[i] <= rises_out[i] + 8'h01;
    end
  end
endmodule

// ==== bench/tb_top.sv ====
// Purpose: directed scenarios for the status lamp sequencer
// Assumes: short, long and update counts shortened to 4, 12 and 50
// Notes:   inputs change at the falling edge only
`timescale 1ns/1ps
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module tb_top;
  import slseq_pkg::*;
  localparam int S = 4, L = 12, U = 50;
  logic clk_in = 1'b0, reset_n_in = 1'b0, clr = 1'b1;
  logic system_fault_in = 1'b0, fw_load_fail_in = 1'b0, fw_update_in = 1'b0;
  logic restore_switch_in = 1'b1, stored_cfg_present_in = 1'b1, type_mismatch_in = 1'b0;
  logic new_cfg_in = 1'b0, download_in = 1'b0, activate_in = 1'b0, activate_done_in = 1'b0;
  logic boot_stage_err_in = 1'b0, main_program_stage_err_in = 1'b0;
  logic [CODE_W-1:0] error_code_in = 4'h0;
  logic blue_status_lamp_out, orange_fault_lamp_out, update_failed_out, blue_module_lamp_out;
  logic green_middle_lamp_out, red_code_lamp_out, store_write_out, restart_out;
  logic restore_enabled_out;
  logic [7:0] rc [5];
  int miscompares = 0, total_checks = 0;
  always #5 clk_in = ~clk_in;
  slseq_top #(.SHORT_CYCLES(S), .LONG_CYCLES(L), .UPDATE_CYCLES(U)) i_dut (.clk_in,
    .reset_n_in, .system_fault_in, .fw_load_fail_in, .fw_update_in, .restore_switch_in,
    .stored_cfg_present_in, .type_mismatch_in, .new_cfg_in, .download_in, .activate_in,
    .activate_done_in, .boot_stage_err_in, .main_program_stage_err_in, .error_code_in,
    .blue_status_lamp_out, .orange_fault_lamp_out, .update_failed_out, .blue_module_lamp_out,
    .green_middle_lamp_out, .red_code_lamp_out, .store_write_out, .restart_out,
    .restore_enabled_out);
  slseq_panel i_panel (.clk_in, .clear_in(clr), .lamps_in({red_code_lamp_out,
    green_middle_lamp_out, blue_module_lamp_out, orange_fault_lamp_out,
    blue_status_lamp_out}), .rises_out(rc));
  task automatic cyc(int n);
    repeat (n) @(negedge clk_in);
  endtask
  task automatic win(int n);
    clr = 1'b1; cyc(1); clr = 1'b0; cyc(n);
  endtask
  task automatic t_ctl();
    cyc(8); win(16);
    `CHK("ctl", 2'b10, {blue_status_lamp_out, orange_fault_lamp_out})
    `CHK("mod", 3'b111, {blue_module_lamp_out, green_middle_lamp_out, red_code_lamp_out})
    `CHK("mod_rise", 8'h00, rc[2] | rc[3] | rc[4])
    `CHK("restore", 1'b0, restore_enabled_out)
    system_fault_in = 1'b1; cyc(4); win(8 * S);
    `CHK("orange_rise", 8'h04, rc[1])
    `CHK("blue_rise", 8'h00, rc[0])
    fw_update_in = 1'b1; cyc(2);
    `CHK("upd", 3'b110, {blue_status_lamp_out, orange_fault_lamp_out, update_failed_out})
    cyc(U);
    `CHK("upd_fail", 1'b1, update_failed_out)
    fw_load_fail_in = 1'b1; cyc(2);
    `CHK("load", 2'b01, {blue_status_lamp_out, orange_fault_lamp_out})
    {system_fault_in, fw_update_in, fw_load_fail_in} = 3'h0; cyc(2);
    `CHK("upd_clr", 1'b0, update_failed_out)
    $display("controller test done");
  endtask
  task automatic t_sos(bit m);
    // the operator sets the restore switch; download also held to test priority
    restore_switch_in = m; stored_cfg_present_in = m; type_mismatch_in = m;
    download_in = 1'b1; cyc(12);
    `CHK("restore", !m, restore_enabled_out)
    win(15 * S + 4 * L);
    for (int i = 2; i < 5; i++) `CHK("sos", 8'h09, rc[i])
    {restore_switch_in, stored_cfg_present_in, type_mismatch_in} = 3'b110;
    cyc(12); win(8 * S);
    for (int i = 2; i < 5; i++) `CHK("dl", 8'h04, rc[i])
    $display("sos and download test done");
  endtask
  task automatic t_act();
    bit b = 1'b0;
    activate_in = 1'b1; cyc(4); win(8 * S);
    for (int i = 2; i < 5; i++) `CHK("act", 8'h02, rc[i])
    repeat (4 * S) if (!b) begin cyc(1); b = blue_module_lamp_out; end
    cyc(S);
    `CHK("act_g", 3'b010, {blue_module_lamp_out, green_middle_lamp_out, red_code_lamp_out})
    cyc(S);
    `CHK("act_r", 3'b001, {blue_module_lamp_out, green_middle_lamp_out, red_code_lamp_out})
    activate_done_in = 1'b1; cyc(1);
    `CHK("restart", 1'b1, restart_out)
    activate_done_in = 1'b0; cyc(1);
    `CHK("restart_end", 1'b0, restart_out)
    {activate_in, download_in} = 2'b00;
    $display("activation test done");
  endtask
  task automatic t_err();
    // both stages flagged: the boot stage error must win
    {boot_stage_err_in, main_program_stage_err_in, error_code_in} = 6'h32; cyc(4);
    // two whole double-flash periods of the blue lamp
    win(2 * (3 * S + L));
    `CHK("boot_blue", 8'h04, rc[2])
    `CHK("boot_red", 8'h04, rc[4])
    `CHK("boot_green", 8'h00, rc[3])
    {boot_stage_err_in, error_code_in} = 5'h01; cyc(4); win(80);
    `CHK("main_blue", 8'h05, rc[2])
    `CHK("main_red", 8'h04, rc[4])
    main_program_stage_err_in = 1'b0; new_cfg_in = 1'b1; cyc(1);
    `CHK("store", 1'b1, store_write_out)
    new_cfg_in = 1'b0; cyc(1);
    `CHK("store_end", 1'b0, store_write_out)
    $display("startup error and store test done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    cyc(8); reset_n_in = 1'b1;
    t_ctl(); t_sos(1'b0); t_sos(1'b1); t_act(); t_err();
    report_and_stop();
  end
  initial begin
    repeat (4000) @(posedge clk_in);
    miscompares++;
    report_and_stop();
  end
endmodule

// ==== design/slseq_pkg.sv ====
// Purpose: constants shared by the status lamp sequencer
// Assumes: 100 MHz clock
// Notes:   flash lengths are plain defaults, shortened in simulation via parameters
package slseq_pkg;
  localparam int unsigned CLK_HZ          = 100_000_000;
  localparam int unsigned SHORT_FLASH_MS  = 200;
  localparam int unsigned LONG_FLASH_MS   = 600;
  localparam int unsigned UPDATE_LIMIT_S  = 120;
  localparam int unsigned SHORT_CYC       = SHORT_FLASH_MS * (CLK_HZ / 1000);
  localparam int unsigned LONG_CYC        = LONG_FLASH_MS * (CLK_HZ / 1000);
  localparam longint unsigned UPDATE_CYC  = 64'(UPDATE_LIMIT_S) * 64'(CLK_HZ);
  localparam int unsigned SYNC_STAGES     = 3;
  localparam int unsigned CODE_W          = 4;
  localparam logic        RESTORE_SW_ON   = 1'b1;

  typedef enum logic [2:0] {
    SLSEQ_NORMAL,
    SLSEQ_SOS,
    SLSEQ_BOOT_ERR,
    SLSEQ_MAIN_ERR,
    SLSEQ_DOWNLOAD,
    SLSEQ_ACTIVATE
  } slseq_mode_t;

  // one step of a pattern: lamp lit or dark, short or long slot
  typedef enum logic [1:0] {
    SLSEQ_SLOT_SHORT,
    SLSEQ_SLOT_LONG,
    SLSEQ_SLOT_GAP
  } slseq_slot_t;
endpackage

// ==== design/slseq_top.sv ====
// Purpose: turns controller and module conditions into lamp drive
// Assumes: condition inputs are synchronous to clk_in except the socket switch
// Notes:   module lamp outputs are high while the lamp is lit
//
// Behaviour
// - normal controller: blue steady on, orange off.
// - system fault: orange flashes periodically, blue stays steady on.
// - firmware load failure: orange steady on, blue off.
// - during update both lamps steady; beyond two minutes flag failure.
// - normal module: blue, green and red all steady on.
// - patterns are made of short and long flashes.
// - restore enabled and stored configuration absent: show SOS.
// - stored module type differs from inserted type: show SOS.
// - new configuration received: also write it to socket store.
// - firmware download: module lamps flash download pattern.
// - activation: lamps flash one after another top to bottom.
// - after activation finishes the module restarts.
// - boot stage startup error: blue double flashes repeatedly.
// - main program stage startup error: blue single flashes repeatedly.
// - startup failure: red lamp flashes the error code.
// - socket switch 8 off enables restore mode, on disables.
`timescale 1ns/1ps
module slseq_top
  import slseq_pkg::*;
#(
  parameter int unsigned     SHORT_CYCLES  = SHORT_CYC,
  parameter int unsigned     LONG_CYCLES   = LONG_CYC,
  parameter longint unsigned UPDATE_CYCLES = UPDATE_CYC
) (
  // clock and reset
  input  wire logic              clk_in,
  input  wire logic              reset_n_in,
  // controller conditions
  input  wire logic              system_fault_in,
  input  wire logic              fw_load_fail_in,
  input  wire logic              fw_update_in,
  // module conditions
  input  wire logic              restore_switch_in,
  input  wire logic              stored_cfg_present_in,
  input  wire logic              type_mismatch_in,
  input  wire logic              new_cfg_in,
  input  wire logic              download_in,
  input  wire logic              activate_in,
  input  wire logic              activate_done_in,
  input  wire logic              boot_stage_err_in,
  input  wire logic              main_program_stage_err_in,
  input  wire logic [CODE_W-1:0] error_code_in,
  // controller lamps
  output logic                   blue_status_lamp_out,
  output logic                   orange_fault_lamp_out,
  output logic                   update_failed_out,
  // module lamps
  output logic                   blue_module_lamp_out,
  output logic                   green_middle_lamp_out,
  output logic                   red_code_lamp_out,
  // socket store and restart
  output logic                   store_write_out,
  output logic                   restart_out,
  output logic                   restore_enabled_out
);

  // refused at elaboration: a slot counter cannot time a slot shorter than two cycles
  if (SHORT_CYCLES < 2 || LONG_CYCLES <= SHORT_CYCLES || UPDATE_CYCLES < 2) begin : g_bad_len
    $error("slseq_top: flash lengths must satisfy 2 <= short < long");
  end

  localparam int unsigned CNT_W = $clog2(LONG_CYCLES + 1);

  // socket switch comes from a pin: three flops, change taken when last two agree
  logic [SYNC_STAGES-1:0] sw_sync;
  logic                   sw_level;
  always_ff @(posedge clk_in) begin
    // reset to the ON level so release does not fake a switch change to OFF
    if (!reset_n_in) begin
      sw_sync <= {SYNC_STAGES{RESTORE_SW_ON}};
    end else begin
      sw_sync <= {sw_sync[SYNC_STAGES-2:0], restore_switch_in};
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sw_level <= RESTORE_SW_ON;
    end else if (sw_sync[2] == sw_sync[1]) begin
      sw_level <= sw_sync[1];
    end
  end
  wire restore_en = (sw_level != RESTORE_SW_ON);

  // mode selection: any error pattern outranks any progress pattern
  slseq_mode_t mode;
  slseq_mode_t next_mode;
  always_comb begin
    if ((restore_en && !stored_cfg_present_in) || type_mismatch_in) begin
      next_mode = SLSEQ_SOS;
    end else if (boot_stage_err_in) begin
      next_mode = SLSEQ_BOOT_ERR;
    end else if (main_program_stage_err_in) begin
      next_mode = SLSEQ_MAIN_ERR;
    end else if (activate_in) begin
      next_mode = SLSEQ_ACTIVATE;
    end else if (download_in) begin
      next_mode = SLSEQ_DOWNLOAD;
    end else begin
      next_mode = SLSEQ_NORMAL;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      mode <= SLSEQ_NORMAL;
    end else begin
      mode <= next_mode;
    end
  end
  wire mode_change = (next_mode != mode);

  // step sequencer: each pattern is a list of lit/dark slots of short or long length
  logic [CNT_W-1:0] slot_cnt;
  logic [4:0]       step;
  logic [2:0]       lamps;     // {blue, green, red} for this step
  slseq_slot_t      slot_len;
  logic             last_step;

  function automatic logic [CNT_W-1:0] slot_cycles(input slseq_slot_t s);
    case (s)
      SLSEQ_SLOT_LONG: slot_cycles = CNT_W'(LONG_CYCLES);
      default:         slot_cycles = CNT_W'(SHORT_CYCLES);
    endcase
  endfunction

  // sos: three short, three long, three short, then a long pause
  always_comb begin
    lamps     = 3'b000;
    slot_len  = SLSEQ_SLOT_SHORT;
    last_step = 1'b0;
    case (mode)
      SLSEQ_SOS: begin
        lamps     = step[0] ? 3'b000 : 3'b111;
        slot_len  = (step >= 5'd6 && step < 5'd12 && !step[0]) ? SLSEQ_SLOT_LONG
                                                                 : SLSEQ_SLOT_SHORT;
        if (step == 5'd18) begin
          lamps    = 3'b000;
          slot_len = SLSEQ_SLOT_LONG;
        end
        last_step = (step == 5'd18);
      end
      SLSEQ_DOWNLOAD: begin
        lamps     = step[0] ? 3'b000 : 3'b111;
        last_step = (step == 5'd1);
      end
      SLSEQ_ACTIVATE: begin
        case (step)
          5'd0:    lamps = 3'b100;
          5'd1:    lamps = 3'b010;
          5'd2:    lamps = 3'b001;
          default: lamps = 3'b000;
        endcase
        last_step = (step == 5'd3);
      end
      SLSEQ_BOOT_ERR: begin
        lamps     = (step == 5'd0 || step == 5'd2) ? 3'b100 : 3'b000;
        slot_len  = (step == 5'd3) ? SLSEQ_SLOT_LONG : SLSEQ_SLOT_SHORT;
        last_step = (step == 5'd3);
      end
      SLSEQ_MAIN_ERR: begin
        lamps     = (step == 5'd0) ? 3'b100 : 3'b000;
        slot_len  = (step == 5'd1) ? SLSEQ_SLOT_LONG : SLSEQ_SLOT_SHORT;
        last_step = (step == 5'd1);
      end
      default: begin
        lamps     = 3'b111;
        last_step = 1'b1;
      end
    endcase
  end

  wire slot_end = (slot_cnt >= slot_cycles(slot_len) - CNT_W'(1));
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || mode_change) begin
      slot_cnt <= '0;
      step     <= '0;
    end else if (slot_end) begin
      slot_cnt <= '0;
      step     <= last_step ? 5'd0 : step + 5'd1;
    end else begin
      slot_cnt <= slot_cnt + CNT_W'(1);
    end
  end

  // red error code: code value short flashes, then a long pause
  logic [CNT_W-1:0]  code_cnt;
  logic [CODE_W:0]   code_step;
  logic [CODE_W-1:0] code_hold;
  wire startup_err  = (mode == SLSEQ_BOOT_ERR) || (mode == SLSEQ_MAIN_ERR);
  wire code_pause   = (code_step >= {code_hold, 1'b0});
  wire code_end     = (code_cnt >= (code_pause ? CNT_W'(LONG_CYCLES) : CNT_W'(SHORT_CYCLES))
                       - CNT_W'(1));
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || mode_change) begin
      code_cnt  <= '0;
      code_step <= '0;
      code_hold <= '0;
    end else if (code_end) begin
      code_cnt <= '0;
      if (code_pause) begin
        code_step <= '0;
        code_hold <= error_code_in;
      end else begin
        code_step <= code_step + (CODE_W+1)'(1);
      end
    end else begin
      code_cnt <= code_cnt + CNT_W'(1);
    end
  end
  wire code_lit = !code_pause && !code_step[0];

  // module lamp drive
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      blue_module_lamp_out  <= 1'b0;
      green_middle_lamp_out <= 1'b0;
      red_code_lamp_out     <= 1'b0;
    end else begin
      blue_module_lamp_out  <= lamps[2];
      green_middle_lamp_out <= lamps[1];
      red_code_lamp_out     <= startup_err ? code_lit : lamps[0];
    end
  end

  // controller lamps: fault flash is a plain short on/off blink
  logic [CNT_W-1:0] blink_cnt;
  logic             blink;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      blink_cnt <= '0;
      blink     <= 1'b1;
    end else if (blink_cnt >= CNT_W'(SHORT_CYCLES) - CNT_W'(1)) begin
      blink_cnt <= '0;
      blink     <= !blink;
    end else begin
      blink_cnt <= blink_cnt + CNT_W'(1);
    end
  end

  // update watchdog, counter saturates so the failure flag stays up
  localparam int unsigned UPD_W = $clog2(UPDATE_CYCLES + 1);
  logic [UPD_W-1:0] upd_cnt;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in || !fw_update_in) begin
      upd_cnt <= '0;
    end else if (upd_cnt < UPD_W'(UPDATE_CYCLES)) begin
      upd_cnt <= upd_cnt + UPD_W'(1);
    end
  end
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      update_failed_out <= 1'b0;
    end else begin
      update_failed_out <= fw_update_in && (upd_cnt >= UPD_W'(UPDATE_CYCLES));
    end
  end

  // load failure outranks update, which outranks a running fault
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      blue_status_lamp_out  <= 1'b0;
      orange_fault_lamp_out <= 1'b0;
    end else if (fw_load_fail_in) begin
      blue_status_lamp_out  <= 1'b0;
      orange_fault_lamp_out <= 1'b1;
    end else if (fw_update_in) begin
      blue_status_lamp_out  <= 1'b1;
      orange_fault_lamp_out <= 1'b1;
    end else if (system_fault_in) begin
      blue_status_lamp_out  <= 1'b1;
      orange_fault_lamp_out <= blink;
    end else begin
      blue_status_lamp_out  <= 1'b1;
      orange_fault_lamp_out <= 1'b0;
    end
  end

  // store write echo of new_cfg_in and restart pulse
  logic act_done_d;
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      store_write_out     <= 1'b0;
      restart_out         <= 1'b0;
      act_done_d          <= 1'b0;
      restore_enabled_out <= 1'b0;
    end else begin
      store_write_out     <= new_cfg_in;
      act_done_d          <= activate_done_in;
      restart_out         <= activate_done_in && !act_done_d;
      restore_enabled_out <= restore_en;
    end
  end

endmodule
